// >>> hdl/pafo_pkg.sv
/*
 * Package for the port alternate function override block.
 * Holds pin positions, reset values and the clock-output divider default.
 * Assumes a single system clock domain and no register bus.
 */
`default_nettype none

package pafo_pkg;

   // Width of each general purpose port.
   localparam int PAFO_PORT_W = 8;

   // Pin positions on port B.
   localparam int PB_SPI_CLK   = 7;   // Serial clock, timer 3/4 compare B.
   localparam int PB_SPI_MISO  = 6;   // Master in / slave out, timer 3 compare A.
   localparam int PB_SPI_MOSI  = 5;   // Master out / slave in.
   localparam int PB_SPI_SEL   = 4;   // Slave select, timer 0 compare B.
   localparam int PB_CMP0A     = 3;   // Timer 0 compare A.
   localparam int PB_IRQ2      = 2;   // External interrupt two.
   localparam int PB_CLKOUT    = 1;   // Divided clock output.
   localparam int PB_XCK       = 0;   // Usart A external clock.

   // Pin positions on port C.
   localparam int PC_XTAL_OUT  = 7;   // Timer crystal output.
   localparam int PC_XTAL_IN   = 6;   // Timer crystal input.
   localparam int PC_TDI       = 5;   // Test data input.
   localparam int PC_TDO       = 4;   // Test data output, timer 4 compare A.
   localparam int PC_TMS       = 3;   // Test mode select.
   localparam int PC_TCK       = 2;   // Test clock.
   localparam int PC_TW_DATA   = 1;   // Two-wire data.
   localparam int PC_TW_CLK    = 0;   // Two-wire clock.

   // Reset value of every pin control vector: input, no pull-up, low, input off, bar a fuse-held clock output pin.
   localparam logic [7:0] PAFO_RST_VEC = 8'h00;

   // Default division of the system clock for the clock output pin.
   localparam int PAFO_CLK_DIV_DEF = 2;

   // Width of the clock output divider counter.
   localparam int PAFO_DIV_W = 8;

endpackage

`default_nettype wire

// >>> hdl/pafo_top.sv
/*
 * Alternate function override logic for ports B and C.
 * Each pin's pull-up, drive enable, drive value and digital input enable are
 * taken from the port settings unless an on-chip unit overrides them.
 * Assumes all peripheral and port control inputs come from logic on REF_CLK;
 * the raw pin levels and the fuse come from outside and are synchronised.
 */
`default_nettype none

module pafo_top
   import pafo_pkg::*;
#(
   parameter int CLK_DIV = PAFO_CLK_DIV_DEF   // Divider for the clock output.
) (
   // Clock, reset and enable.
   input  wire logic       REF_CLK,
   input  wire logic       RST,
   input  wire logic       CLK_EN,
   // Port register settings.
   input  wire logic [7:0] PORT_B_VALUE,
   input  wire logic [7:0] PORT_B_DIRECTION,
   input  wire logic [7:0] PORT_C_VALUE,
   input  wire logic [7:0] PORT_C_DIRECTION,
   input  wire logic       GLOBAL_PULLUP_DISABLE,
   input  wire logic       SLEEP_INPUT_OFF,
   // Configuration fuse and pin change control.
   input  wire logic       CLOCK_OUTPUT_FUSE,
   input  wire logic [7:0] PIN_CHANGE_MASK_B,
   input  wire logic [7:0] PIN_CHANGE_MASK_C,
   input  wire logic       PIN_CHANGE_GROUP_B_ENABLE,
   input  wire logic       PIN_CHANGE_GROUP_C_ENABLE,
   input  wire logic       EXTERNAL_IRQ_TWO_ENABLE,
   // Serial peripheral interface A.
   input  wire logic       SPI_A_ENABLE,
   input  wire logic       SPI_MASTER_SELECT,
   input  wire logic       SPI_CLK_OUT,
   input  wire logic       SPI_MASTER_OUT,
   input  wire logic       SPI_SLAVE_OUT,
   // Timers.
   input  wire logic       TIMER3_COMPARE_A_EN,
   input  wire logic       TIMER3_COMPARE_A_OUT,
   input  wire logic       TIMER34_COMPARE_B_EN,
   input  wire logic       TIMER3_COMPARE_B_OUT,
   input  wire logic       TIMER4_COMPARE_B_OUT,
   input  wire logic       TIMER0_COMPARE_A_EN,
   input  wire logic       TIMER0_COMPARE_A_OUT,
   input  wire logic       TIMER0_COMPARE_B_EN,
   input  wire logic       TIMER0_COMPARE_B_OUT,
   input  wire logic       TIMER4_COMPARE_A_EN,
   input  wire logic       TIMER4_COMPARE_A_OUT,
   input  wire logic       ASYNC_TIMER_CLOCK_SELECT,
   input  wire logic       EXTERNAL_CLOCK_OPTION,
   // Usart A.
   input  wire logic       USART_MODE_SELECT,
   input  wire logic       USART_A_CLOCK_OUT,
   // Test access port.
   input  wire logic       TEST_PORT_ENABLE,
   input  wire logic       INSTR_SHIFT_STATE,
   input  wire logic       DATA_SHIFT_STATE,
   input  wire logic       TEST_DATA_OUT,
   // Two-wire interface.
   input  wire logic       TWO_WIRE_ENABLE,
   input  wire logic       TWO_WIRE_DATA_OUT,
   input  wire logic       TWO_WIRE_CLOCK_OUT,
   // Raw pin levels from the pads.
   input  wire logic [7:0] PIN_B_LEVEL,
   input  wire logic [7:0] PIN_C_LEVEL,
   // Pad controls for port B.
   output logic [7:0]      PULLUP_B,
   output logic [7:0]      DRIVE_EN_B,
   output logic [7:0]      DRIVE_VAL_B,
   output logic [7:0]      INPUT_EN_B,
   // Pad controls for port C.
   output logic [7:0]      PULLUP_C,
   output logic [7:0]      DRIVE_EN_C,
   output logic [7:0]      DRIVE_VAL_C,
   output logic [7:0]      INPUT_EN_C,
   // Gated digital inputs towards the peripherals.
   output logic [7:0]      DATA_IN_B,
   output logic [7:0]      DATA_IN_C
);

   // The divider counts half periods, so the division must be even and fit.
   if (CLK_DIV < 2 || CLK_DIV % 2 != 0 || CLK_DIV / 2 > 2 ** PAFO_DIV_W) begin : g_chk
      $error("CLK_DIV must be even, at least 2 and fit the divider counter.");
   end

   // Half period of the divided clock, less one, at counter width.
   localparam logic [PAFO_DIV_W-1:0] HALF_M1 = PAFO_DIV_W'(CLK_DIV / 2 - 1);

   // Main block state; everything here is cleared by reset.
   typedef struct packed {
      logic [7:0] b_sync1;   // First synchroniser stage, port B pins.
      logic [7:0] b_sync2;   // Second synchroniser stage, port B pins.
      logic [7:0] c_sync1;   // First synchroniser stage, port C pins.
      logic [7:0] c_sync2;   // Second synchroniser stage, port C pins.
      logic [7:0] pu_b;      // Port B pull-up.
      logic [7:0] dd_b;      // Port B drive enable; bit 1 lives in the clock path.
      logic [7:0] pv_b;      // Port B drive value; bit 1 lives in the clock path.
      logic [7:0] die_b;     // Port B digital input enable.
      logic [7:0] pu_c;      // Port C pull-up.
      logic [7:0] dd_c;      // Port C drive enable.
      logic [7:0] pv_c;      // Port C drive value.
      logic [7:0] die_c;     // Port C digital input enable.
      logic [7:0] di_b;      // Gated port B input.
      logic [7:0] di_c;      // Gated port C input.
   } pafo_state_t;

   // Clock output path state. It has no reset so that the divided clock keeps
   // running while the rest of the block is held; power-up values are given.
   typedef struct packed {
      logic                  fuse_s1;   // First synchroniser stage of the fuse.
      logic                  fuse_s2;   // Second synchroniser stage of the fuse.
      logic [PAFO_DIV_W-1:0] div_cnt;   // Half period counter.
      logic                  clk_div;   // Divided clock.
      logic                  dd_b1;     // Drive enable of the clock output pin.
      logic                  pv_b1;     // Drive value of the clock output pin.
   } pafo_ck_t;

   pafo_state_t st_q;                   // Registered block state.
   pafo_state_t st_d;                   // Next block state.
   pafo_ck_t    ck_q = '0;              // Registered clock path state.
   pafo_ck_t    ck_d;                   // Next clock path state.

   // Override terms for one port: enables and values per pin.
   logic [7:0] b_puoe, b_puov, b_ddoe, b_ddov, b_pvoe, b_pvov, b_dieoe, b_dieov;
   logic [7:0] c_puoe, c_puov, c_ddoe, c_ddov, c_pvoe, c_pvov, c_dieoe, c_dieov;
   logic       spi_slave;               // SPI enabled as slave.
   logic       spi_master;              // SPI enabled as master.
   logic       xtal_out_ov;             // Crystal output pin taken by oscillator.

   // Override table for both ports, straight from the unit controls.
   always_comb begin
      spi_slave   = SPI_A_ENABLE & ~SPI_MASTER_SELECT;
      spi_master  = SPI_A_ENABLE & SPI_MASTER_SELECT;
      xtal_out_ov = ASYNC_TIMER_CLOCK_SELECT & ~EXTERNAL_CLOCK_OPTION;
      b_puoe = 8'h00;
      b_ddoe = 8'h00;
      b_ddov = 8'h00;
      // Pull-up follows the port bit unless pull-ups are disabled globally.
      b_puov = PORT_B_VALUE & ~{8{GLOBAL_PULLUP_DISABLE}};
      // Slave clock, slave input and select are forced to input as a slave.
      b_puoe[PB_SPI_CLK]  = spi_slave;
      b_ddoe[PB_SPI_CLK]  = spi_slave;
      b_puoe[PB_SPI_SEL]  = spi_slave;
      b_ddoe[PB_SPI_SEL]  = spi_slave;
      b_puoe[PB_SPI_MOSI] = spi_slave;
      b_ddoe[PB_SPI_MOSI] = spi_slave;
      // The master receives on the MISO pin, so it is forced to input then.
      b_puoe[PB_SPI_MISO] = spi_master;
      b_ddoe[PB_SPI_MISO] = spi_master;
      // Drive values; compare outputs share pins with the SPI signals.
      b_pvoe = 8'h00;
      b_pvov = 8'h00;
      b_pvoe[PB_SPI_CLK]  = spi_master | TIMER34_COMPARE_B_EN;
      b_pvov[PB_SPI_CLK]  = (spi_master & SPI_CLK_OUT)
                          | TIMER3_COMPARE_B_OUT | TIMER4_COMPARE_B_OUT;
      b_pvoe[PB_SPI_MISO] = spi_slave | TIMER3_COMPARE_A_EN;
      b_pvov[PB_SPI_MISO] = (spi_slave & SPI_SLAVE_OUT) | TIMER3_COMPARE_A_OUT;
      b_pvoe[PB_SPI_MOSI] = spi_master;
      b_pvov[PB_SPI_MOSI] = SPI_MASTER_OUT;
      b_pvoe[PB_SPI_SEL]  = TIMER0_COMPARE_B_EN;
      b_pvov[PB_SPI_SEL]  = TIMER0_COMPARE_B_OUT;
      b_pvoe[PB_CMP0A]    = TIMER0_COMPARE_A_EN;
      b_pvov[PB_CMP0A]    = TIMER0_COMPARE_A_OUT;
      // The usart clock replaces the value only in synchronous mode; the
      // direction stays with the port bit, which picks drive or receive.
      b_pvoe[PB_XCK]      = USART_MODE_SELECT;
      b_pvov[PB_XCK]      = USART_A_CLOCK_OUT;
      // Input enable is forced on for pin change sources and irq two.
      b_dieoe = PIN_CHANGE_MASK_B & {8{PIN_CHANGE_GROUP_B_ENABLE}};
      b_dieoe[PB_IRQ2] = EXTERNAL_IRQ_TWO_ENABLE | b_dieoe[PB_IRQ2];
      b_dieov = 8'hFF;

      // Port C: crystal, test port and two-wire pins.
      c_puoe = 8'h00;
      c_puov = 8'h00;
      c_ddoe = 8'h00;
      c_ddov = 8'h00;
      c_pvoe = 8'h00;
      c_pvov = 8'h00;
      c_dieoe = PIN_CHANGE_MASK_C & {8{PIN_CHANGE_GROUP_C_ENABLE}};
      c_dieov = 8'hFF;
      // Crystal pins: the output pin is left alone for an external clock.
      c_puoe[PC_XTAL_OUT]  = xtal_out_ov;
      c_ddoe[PC_XTAL_OUT]  = xtal_out_ov;
      c_dieoe[PC_XTAL_OUT] = xtal_out_ov | c_dieoe[PC_XTAL_OUT];
      c_dieov[PC_XTAL_OUT] = ~ASYNC_TIMER_CLOCK_SELECT;
      c_puoe[PC_XTAL_IN]   = ASYNC_TIMER_CLOCK_SELECT;
      c_ddoe[PC_XTAL_IN]   = ASYNC_TIMER_CLOCK_SELECT;
      c_dieoe[PC_XTAL_IN]  = ASYNC_TIMER_CLOCK_SELECT | c_dieoe[PC_XTAL_IN];
      // An external clock still needs the digital input of the crystal pin.
      c_dieov[PC_XTAL_IN]  = EXTERNAL_CLOCK_OPTION | ~ASYNC_TIMER_CLOCK_SELECT;
      // Test port inputs: pull-up on, input, digital input kept on.
      c_puoe[PC_TDI] = TEST_PORT_ENABLE;
      c_puov[PC_TDI] = 1'b1;
      c_ddoe[PC_TDI] = TEST_PORT_ENABLE;
      c_puoe[PC_TMS] = TEST_PORT_ENABLE;
      c_puov[PC_TMS] = 1'b1;
      c_ddoe[PC_TMS] = TEST_PORT_ENABLE;
      c_puoe[PC_TCK] = TEST_PORT_ENABLE;
      c_puov[PC_TCK] = 1'b1;
      c_ddoe[PC_TCK] = TEST_PORT_ENABLE;
      c_dieoe[PC_TDI] = TEST_PORT_ENABLE | c_dieoe[PC_TDI];
      c_dieov[PC_TDI] = 1'b1;
      c_dieoe[PC_TMS] = TEST_PORT_ENABLE | c_dieoe[PC_TMS];
      c_dieoe[PC_TCK] = TEST_PORT_ENABLE | c_dieoe[PC_TCK];
      // Test data output drives only while shifting, so the pin is released
      // between scans; the timer compare output may also claim the pin.
      c_puoe[PC_TDO]  = TEST_PORT_ENABLE;
      c_puov[PC_TDO]  = 1'b1;
      c_ddoe[PC_TDO]  = TEST_PORT_ENABLE | TIMER4_COMPARE_A_EN;
      c_ddov[PC_TDO]  = INSTR_SHIFT_STATE | DATA_SHIFT_STATE
                      | TIMER4_COMPARE_A_OUT;
      c_pvoe[PC_TDO]  = TEST_PORT_ENABLE | TIMER4_COMPARE_A_EN;
      c_pvov[PC_TDO]  = TEST_PORT_ENABLE ? TEST_DATA_OUT : TIMER4_COMPARE_A_OUT;
      c_dieoe[PC_TDO] = TEST_PORT_ENABLE | c_dieoe[PC_TDO];
      // Two-wire pins: value from the unit, pull-up from the port bit.
      c_puoe[PC_TW_DATA] = TWO_WIRE_ENABLE;
      c_puov[PC_TW_DATA] = PORT_C_VALUE[PC_TW_DATA] & ~GLOBAL_PULLUP_DISABLE;
      c_ddoe[PC_TW_DATA] = TWO_WIRE_ENABLE;
      c_pvoe[PC_TW_DATA] = TWO_WIRE_ENABLE;
      c_pvov[PC_TW_DATA] = TWO_WIRE_DATA_OUT;
      c_puoe[PC_TW_CLK]  = TWO_WIRE_ENABLE;
      c_puov[PC_TW_CLK]  = PORT_C_VALUE[PC_TW_CLK] & ~GLOBAL_PULLUP_DISABLE;
      c_ddoe[PC_TW_CLK]  = TWO_WIRE_ENABLE;
      c_pvoe[PC_TW_CLK]  = TWO_WIRE_ENABLE;
      c_pvov[PC_TW_CLK]  = TWO_WIRE_CLOCK_OUT;
   end

   // Next state: apply each override per pin, else the port settings.
   always_comb begin
      st_d = st_q;
      // Pins are asynchronous; only the second stage is read further on.
      st_d.b_sync1 = PIN_B_LEVEL;
      st_d.b_sync2 = st_q.b_sync1;
      st_d.c_sync1 = PIN_C_LEVEL;
      st_d.c_sync2 = st_q.c_sync1;
      for (int i = 0; i < PAFO_PORT_W; i++) begin
         // Without an override, a pull-up only exists on an input with pull-ups allowed.
         st_d.pu_b[i]  = b_puoe[i] ? b_puov[i]
                       : PORT_B_VALUE[i] & ~PORT_B_DIRECTION[i] & ~GLOBAL_PULLUP_DISABLE;
         st_d.dd_b[i]  = b_ddoe[i] ? b_ddov[i] : PORT_B_DIRECTION[i];
         st_d.pv_b[i]  = b_pvoe[i] ? b_pvov[i] : PORT_B_VALUE[i];
         st_d.die_b[i] = b_dieoe[i] ? b_dieov[i] : ~SLEEP_INPUT_OFF;
         st_d.pu_c[i]  = c_puoe[i] ? c_puov[i]
                       : PORT_C_VALUE[i] & ~PORT_C_DIRECTION[i] & ~GLOBAL_PULLUP_DISABLE;
         st_d.dd_c[i]  = c_ddoe[i] ? c_ddov[i] : PORT_C_DIRECTION[i];
         st_d.pv_c[i]  = c_pvoe[i] ? c_pvov[i] : PORT_C_VALUE[i];
         st_d.die_c[i] = c_dieoe[i] ? c_dieov[i] : ~SLEEP_INPUT_OFF;
      end
      // The clock output pin's drive comes from the clock path instead.
      st_d.pu_b[PB_CLKOUT] = PORT_B_VALUE[PB_CLKOUT] & ~PORT_B_DIRECTION[PB_CLKOUT]
                           & ~GLOBAL_PULLUP_DISABLE & ~ck_q.fuse_s2;
      st_d.dd_b[PB_CLKOUT] = 1'b0;
      st_d.pv_b[PB_CLKOUT] = 1'b0;
      // Peripherals see a pin only while its digital input is enabled.
      st_d.di_b = st_q.b_sync2 & st_q.die_b;
      st_d.di_c = st_q.c_sync2 & st_q.die_c;
   end

   // Clock output path: divider and the pin drive, on a register without reset.
   always_comb begin
      ck_d = ck_q;
      ck_d.fuse_s1 = CLOCK_OUTPUT_FUSE;
      ck_d.fuse_s2 = ck_q.fuse_s1;
      if (ck_q.div_cnt >= HALF_M1) begin
         ck_d.div_cnt = '0;
         ck_d.clk_div = ~ck_q.clk_div;
      end else begin
         ck_d.div_cnt = ck_q.div_cnt + PAFO_DIV_W'(1);
      end
      // A programmed fuse takes the pin whatever the port bits say, and also
      // while reset is held; otherwise reset parks the pin as an input.
      if (ck_q.fuse_s2) begin
         ck_d.dd_b1 = 1'b1;
         ck_d.pv_b1 = ck_q.clk_div;
      end else if (RST) begin
         ck_d.dd_b1 = 1'b0;
         ck_d.pv_b1 = 1'b0;
      end else begin
         ck_d.dd_b1 = PORT_B_DIRECTION[PB_CLKOUT];
         ck_d.pv_b1 = PORT_B_VALUE[PB_CLKOUT];
      end
   end

   // Block state register with asynchronous reset and clock enable.
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         st_q <= '0;
      end else if (CLK_EN) begin
         st_q <= st_d;
      end
   end

   // Clock path register; deliberately outside reset so the output runs on.
   always_ff @(posedge REF_CLK) begin
      if (CLK_EN) begin
         ck_q <= ck_d;
      end
   end

   // Outputs come straight from the registers above.
   assign PULLUP_B    = st_q.pu_b;
   assign DRIVE_EN_B  = {st_q.dd_b[7:2], ck_q.dd_b1, st_q.dd_b[0]};
   assign DRIVE_VAL_B = {st_q.pv_b[7:2], ck_q.pv_b1, st_q.pv_b[0]};
   assign INPUT_EN_B  = st_q.die_b;
   assign PULLUP_C    = st_q.pu_c;
   assign DRIVE_EN_C  = st_q.dd_c;
   assign DRIVE_VAL_C = st_q.pv_c;
   assign INPUT_EN_C  = st_q.die_c;
   assign DATA_IN_B   = st_q.di_b;
   assign DATA_IN_C   = st_q.di_c;

endmodule

`default_nettype wire

// >>> bench/pafo_props.sv
/* Port checks for the override block, bound to pafo_top from the bench.
   Assumes CLK_DIV stays at 2, so the divided clock flips on every edge. */
`default_nettype none
module pafo_props (
   // Clock, reset and watched controls.
   input wire logic       REF_CLK, RST, CLK_EN, GLOBAL_PULLUP_DISABLE, CLOCK_OUTPUT_FUSE,
   input wire logic       SPI_A_ENABLE, SPI_MASTER_SELECT, EXTERNAL_IRQ_TWO_ENABLE,
   input wire logic       USART_MODE_SELECT, USART_A_CLOCK_OUT, TIMER4_COMPARE_A_OUT,
   input wire logic       TEST_PORT_ENABLE, INSTR_SHIFT_STATE, DATA_SHIFT_STATE, TEST_DATA_OUT,
   input wire logic       TWO_WIRE_ENABLE, TWO_WIRE_DATA_OUT, TWO_WIRE_CLOCK_OUT,
   input wire logic [7:0] PORT_B_VALUE, PORT_C_VALUE,
   // Watched pad controls.
   input wire logic [7:0] PULLUP_B, DRIVE_EN_B, DRIVE_VAL_B, INPUT_EN_B,
   input wire logic [7:0] PULLUP_C, DRIVE_EN_C, DRIVE_VAL_C
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   // High when the previous edge loaded the pads, so $past names their cause.
   logic live_q;
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) live_q <= 1'b0;
      else live_q <= CLK_EN;
   end
   property p_spi_in; live_q && $past(SPI_A_ENABLE && !SPI_MASTER_SELECT)
      |-> (DRIVE_EN_B & 8'hB0) == 8'h00; endproperty
   a_spi_in: assert property (p_spi_in) else $error("slave pins not input");
   property p_spi_pu; live_q && $past(SPI_A_ENABLE && !SPI_MASTER_SELECT)
      |-> PULLUP_B[7] == $past(PORT_B_VALUE[7] && !GLOBAL_PULLUP_DISABLE); endproperty
   a_spi_pu: assert property (p_spi_pu) else $error("slave pull-up wrong");
   property p_tw; live_q && $past(TWO_WIRE_ENABLE)
      |-> DRIVE_VAL_C[1] == $past(TWO_WIRE_DATA_OUT) && !DRIVE_EN_C[1]; endproperty
   a_tw: assert property (p_tw) else $error("two-wire data pin wrong");
   property p_twc; live_q && $past(TWO_WIRE_ENABLE)
      |-> DRIVE_VAL_C[0] == $past(TWO_WIRE_CLOCK_OUT)
      && PULLUP_C[0] == $past(PORT_C_VALUE[0] && !GLOBAL_PULLUP_DISABLE); endproperty
   a_twc: assert property (p_twc) else $error("two-wire clock pin wrong");
   property p_tp; live_q && $past(TEST_PORT_ENABLE)
      |-> PULLUP_C[3] && PULLUP_C[2] && (DRIVE_EN_C & 8'h2C) == 8'h00; endproperty
   a_tp: assert property (p_tp) else $error("test pins not input");
   property p_tdo; live_q && $past(TEST_PORT_ENABLE)
      |-> DRIVE_VAL_C[4] == $past(TEST_DATA_OUT)
      && DRIVE_EN_C[4] == $past(INSTR_SHIFT_STATE || DATA_SHIFT_STATE || TIMER4_COMPARE_A_OUT);
      endproperty
   a_tdo: assert property (p_tdo) else $error("test data out pin wrong");
   property p_irq2; live_q && $past(EXTERNAL_IRQ_TWO_ENABLE) |-> INPUT_EN_B[2]; endproperty
   a_irq2: assert property (p_irq2) else $error("irq two input off");
   property p_xck; live_q && $past(USART_MODE_SELECT)
      |-> DRIVE_VAL_B[0] == $past(USART_A_CLOCK_OUT); endproperty
   a_xck: assert property (p_xck) else $error("usart clock not driven");
   // No disable here: the clock output must keep running through reset.
   property p_divided_clock_out_pin; disable iff (1'b0) (CLOCK_OUTPUT_FUSE && CLK_EN)[*8]
      |-> DRIVE_EN_B[1] && DRIVE_VAL_B[1] != $past(DRIVE_VAL_B[1]); endproperty
   a_divided_clock_out_pin: assert property (p_divided_clock_out_pin) else $error("divided clock not on pin");
   c_slave: cover property (live_q && SPI_A_ENABLE && !SPI_MASTER_SELECT);
   c_shift: cover property (TEST_PORT_ENABLE && INSTR_SHIFT_STATE);
   c_rst_clk: cover property (disable iff (1'b0) RST && DRIVE_EN_B[1]);
endmodule
`default_nettype wire

// >>> bench/pafo_pad_model.sv
/* Board model of the pads: a driven pad shows the block's value, else its
   pull-up, else a level that flips each cycle so a floating pin never looks
   steady. Assumes the block's pad-control port names. */
`default_nettype none
module pafo_pad_model (
   // Clock for the floating pattern.
   input wire logic       REF_CLK,
   // Pad controls from the block.
   input wire logic [7:0] PULLUP_B, DRIVE_EN_B, DRIVE_VAL_B, PULLUP_C, DRIVE_EN_C, DRIVE_VAL_C,
   // Pad levels back to the block.
   output var logic [7:0] PIN_B_LEVEL, PIN_C_LEVEL
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] float_q = 8'h55;  // Alternates every cycle.
   always @(posedge REF_CLK) float_q <= ~float_q;
   // Drive wins, then the pull-up, then the float pattern.
   always_comb begin
      PIN_B_LEVEL = (DRIVE_EN_B & DRIVE_VAL_B) | (~DRIVE_EN_B & (PULLUP_B | float_q));
      PIN_C_LEVEL = (DRIVE_EN_C & DRIVE_VAL_C) | (~DRIVE_EN_C & (PULLUP_C | float_q));
   end
endmodule
`default_nettype wire

// >>> bench/pafo_top_bench.sv
/* Self-checking bench for the override block with the pad model beside it.
   Assumes pafo_pkg, pafo_top, pafo_pad_model and pafo_props compiled first. */
`default_nettype none
module pafo_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import pafo_pkg::*;
   typedef struct {int sel; logic [7:0] m; logic [7:0] e; int lat;} pafo_note_t;
   localparam int PUB = 0, DEB = 1, DVB = 2, IEB = 3, PUC = 4, DEC = 5, DVC = 6, IEC = 7;
   localparam int DIB = 8, DIC = 9;
   logic       REF_CLK, RST, CLK_EN, CLOCK_OUTPUT_FUSE, SLEEP_INPUT_OFF, GLOBAL_PULLUP_DISABLE;
   logic [7:0] PORT_B_VALUE, PORT_B_DIRECTION, PORT_C_VALUE, PORT_C_DIRECTION;
   logic [7:0] PIN_CHANGE_MASK_B, PIN_CHANGE_MASK_C, PIN_B_LEVEL, PIN_C_LEVEL;
   logic       PIN_CHANGE_GROUP_B_ENABLE, PIN_CHANGE_GROUP_C_ENABLE, EXTERNAL_IRQ_TWO_ENABLE;
   logic       SPI_A_ENABLE, SPI_MASTER_SELECT, TIMER3_COMPARE_A_EN, TIMER34_COMPARE_B_EN;
   logic       TIMER0_COMPARE_A_EN, TIMER0_COMPARE_B_EN, TIMER4_COMPARE_A_EN;
   logic       ASYNC_TIMER_CLOCK_SELECT, USART_MODE_SELECT, TEST_PORT_ENABLE, TWO_WIRE_ENABLE;
   logic       SPI_CLK_OUT, SPI_MASTER_OUT, SPI_SLAVE_OUT, TIMER3_COMPARE_A_OUT;
   logic       TIMER3_COMPARE_B_OUT, TIMER4_COMPARE_B_OUT, TIMER0_COMPARE_A_OUT;
   logic       TIMER0_COMPARE_B_OUT, TIMER4_COMPARE_A_OUT, USART_A_CLOCK_OUT, TEST_DATA_OUT;
   logic       TWO_WIRE_DATA_OUT, TWO_WIRE_CLOCK_OUT, INSTR_SHIFT_STATE, DATA_SHIFT_STATE;
   logic       EXTERNAL_CLOCK_OPTION;
   logic [7:0] PULLUP_B, DRIVE_EN_B, DRIVE_VAL_B, INPUT_EN_B, PULLUP_C, DRIVE_EN_C;
   logic [7:0] DRIVE_VAL_C, INPUT_EN_C, DATA_IN_B, DATA_IN_C;
   logic [7:0] outs [10];      // Outputs indexed by the selectors above.
   pafo_note_t notes [$];      // Expected results, oldest first.
   int         fails = 0;
   int         comparisons = 0;
   pafo_top pafo_top_inst (.*);
   pafo_pad_model pafo_pad_model_inst (.*);
   always_comb outs = '{PULLUP_B, DRIVE_EN_B, DRIVE_VAL_B, INPUT_EN_B, PULLUP_C, DRIVE_EN_C,
                        DRIVE_VAL_C, INPUT_EN_C, DATA_IN_B, DATA_IN_C};
   initial begin
      REF_CLK = 1'b0;
      forever #5 REF_CLK = ~REF_CLK;
   end
   // Port pull-up with the global disable applied.
   function automatic logic [7:0] pu(input logic [7:0] v, input logic [7:0] d);
      return v & ~d & {8{~GLOBAL_PULLUP_DISABLE}};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic note(input int sel, input logic [7:0] m, input logic [7:0] e, input int lat = 0);
      notes.push_back('{sel, m, e & m, lat});
   endtask
   // All unit enables off; data-like inputs random.
   task automatic scramble();
      {SPI_A_ENABLE, SPI_MASTER_SELECT, TIMER3_COMPARE_A_EN, TIMER34_COMPARE_B_EN,
       TIMER0_COMPARE_A_EN, TIMER0_COMPARE_B_EN, TIMER4_COMPARE_A_EN, ASYNC_TIMER_CLOCK_SELECT,
       USART_MODE_SELECT, TEST_PORT_ENABLE, TWO_WIRE_ENABLE, EXTERNAL_IRQ_TWO_ENABLE,
       PIN_CHANGE_GROUP_B_ENABLE, PIN_CHANGE_GROUP_C_ENABLE, SLEEP_INPUT_OFF} = '0;
      {SPI_CLK_OUT, SPI_MASTER_OUT, SPI_SLAVE_OUT, TIMER3_COMPARE_A_OUT, TIMER3_COMPARE_B_OUT,
       TIMER4_COMPARE_B_OUT, TIMER0_COMPARE_A_OUT, TIMER0_COMPARE_B_OUT, TIMER4_COMPARE_A_OUT,
       USART_A_CLOCK_OUT, TEST_DATA_OUT, TWO_WIRE_DATA_OUT, TWO_WIRE_CLOCK_OUT, INSTR_SHIFT_STATE,
       DATA_SHIFT_STATE, GLOBAL_PULLUP_DISABLE, EXTERNAL_CLOCK_OPTION} = 17'($urandom);
      {PORT_B_VALUE, PORT_B_DIRECTION, PORT_C_VALUE, PORT_C_DIRECTION} = $urandom;
      {PIN_CHANGE_MASK_B, PIN_CHANGE_MASK_C} = 16'($urandom);
   endtask
   // Waits 12 cycles for the previous notes to drain, then drives just after an edge.
   task automatic start();
      repeat (12) @(posedge REF_CLK);
      #1;
      scramble();
   endtask
   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Monitor: waits each note's latency, then compares the masked output.
   initial begin
      pafo_note_t n;
      forever begin
         wait (notes.size() != 0);
         n = notes.pop_front();
         repeat (n.lat) @(posedge REF_CLK);
         #2;
         check(outs[n.sel] & n.m, n.e);
      end
   end
   initial begin
      repeat (4000) @(posedge REF_CLK);
      fails++;
      end_of_test();
   end
   initial begin
      void'($urandom(73072));
      RST = 1'b1;
      CLK_EN = 1'b1;
      CLOCK_OUTPUT_FUSE = 1'b1;
      scramble();
      repeat (10) @(posedge REF_CLK);
      #1;
      note(DEB, 8'h02, 8'h02, 1);
      repeat (10) @(posedge REF_CLK);
      #1;
      RST = 1'b0;
      CLOCK_OUTPUT_FUSE = 1'b0;
      start();
      note(DIB, PORT_B_DIRECTION, PORT_B_VALUE, 6);
      note(DIC, PORT_C_DIRECTION, PORT_C_VALUE);
      note(PUB, 8'hFF, pu(PORT_B_VALUE, PORT_B_DIRECTION));
      note(DEB, 8'hFF, PORT_B_DIRECTION);
      note(DVB, 8'hFF, PORT_B_VALUE);
      note(IEB, 8'hFF, 8'hFF);
      note(PUC, 8'hFF, pu(PORT_C_VALUE, PORT_C_DIRECTION));
      note(DEC, 8'hFF, PORT_C_DIRECTION);
      for (int m = 0; m < 2; m++) begin
         start();
         SPI_A_ENABLE = 1'b1;
         SPI_MASTER_SELECT = m[0];
         note(DEB, 8'hF0, PORT_B_DIRECTION & (m ? 8'hB0 : 8'h40), 1);
         note(PUB, 8'hF0, pu(PORT_B_VALUE, PORT_B_DIRECTION & (m ? 8'hB0 : 8'h40)));
         note(DVB, 8'hF0, m ? {SPI_CLK_OUT | TIMER3_COMPARE_B_OUT | TIMER4_COMPARE_B_OUT,
            PORT_B_VALUE[6], SPI_MASTER_OUT, PORT_B_VALUE[4], 4'h0} : {PORT_B_VALUE[7],
            SPI_SLAVE_OUT | TIMER3_COMPARE_A_OUT, PORT_B_VALUE[5:4], 4'h0});
      end
      start();
      {TIMER3_COMPARE_A_EN, TIMER34_COMPARE_B_EN, TIMER0_COMPARE_A_EN} = 3'h7;
      {TIMER0_COMPARE_B_EN, TIMER4_COMPARE_A_EN} = 2'h3;
      note(DEB, 8'hFF, PORT_B_DIRECTION, 1);
      note(DEC, 8'h10, {3'h0, INSTR_SHIFT_STATE | DATA_SHIFT_STATE
         | TIMER4_COMPARE_A_OUT, 4'h0});
      start();
      TWO_WIRE_ENABLE = 1'b1;
      note(DEC, 8'h03, 8'h00, 1);
      note(DVC, 8'h03, {6'h0, TWO_WIRE_DATA_OUT, TWO_WIRE_CLOCK_OUT});
      start();
      TEST_PORT_ENABLE = 1'b1;
      SLEEP_INPUT_OFF = 1'b1;
      note(PUC, 8'h3C, 8'h3C, 1);
      note(DEC, 8'h3C, {3'h0, INSTR_SHIFT_STATE | DATA_SHIFT_STATE
         | TIMER4_COMPARE_A_OUT, 4'h0});
      note(IEC, 8'h20, 8'h20);
      for (int x = 0; x < 2; x++) begin
         start();
         ASYNC_TIMER_CLOCK_SELECT = 1'b1;
         EXTERNAL_CLOCK_OPTION = x[0];
         SLEEP_INPUT_OFF = 1'b1;
         note(DEC, 8'hC0, x ? PORT_C_DIRECTION & 8'h80 : 8'h00, 1);
         note(IEC, 8'hC0, x ? 8'h40 : 8'h00);
      end
      start();
      SLEEP_INPUT_OFF = 1'b1;
      PIN_CHANGE_GROUP_B_ENABLE = 1'b1;
      PIN_CHANGE_GROUP_C_ENABLE = 1'b1;
      note(IEB, 8'hFF, PIN_CHANGE_MASK_B, 1);
      note(IEC, 8'hFF, PIN_CHANGE_MASK_C);
      start();
      SLEEP_INPUT_OFF = 1'b1;
      EXTERNAL_IRQ_TWO_ENABLE = 1'b1;
      note(IEB, 8'hFF, 8'h04, 1);
      for (int u = 0; u < 2; u++) begin
         start();
         USART_MODE_SELECT = u[0];
         note(DVB, 8'h01, u ? {7'h0, USART_A_CLOCK_OUT} : PORT_B_VALUE, 1);
         note(DEB, 8'h01, PORT_B_DIRECTION);
      end
      start();
      CLOCK_OUTPUT_FUSE = 1'b1;
      PORT_B_DIRECTION[1] = 1'b0;
      note(DEB, 8'h02, 8'h02, 4);
      repeat (30) @(posedge REF_CLK);
      #1;
      RST = 1'b1;
      note(DEB, 8'hFF, 8'h02, 2);
      for (int i = 0; i < 50 && notes.size() != 0; i++) @(posedge REF_CLK);
      if (notes.size() != 0) fails++;
      end_of_test();
   end
endmodule
bind pafo_top pafo_props pafo_props_inst (.*);
`default_nettype wire
